// File: rtl/charger_regs_pkg.sv
// Constants, field layout and carrier types of the charger register bank
// Assumes a byte-wide register port driven by the I2C slave logic
// Overview of operation
// - Fast-charge current code is read/write bits 6..4 of register 0x04
// - Termination current code is read/write bits 2..0 of register 0x04
// - Override bit clear: charge current follows the fast-charge code
// - Override bit set: fast-charge code ignored, fixed low current used
// - Bit 4 of 0x05 reads one while special charger regulates bus
// - Special-charger flag reads zero whenever special charging is inactive
// - Input regulation level code is read/write bits 2..0 of register 0x05
// - Bit 7 of 0x06 clear enables the 32 s timer, set disables
// - Safety current code is read/write bits 6..4 of register 0x06
// - Safety voltage code bits 3..0 of 0x06; codes above 1100 saturate in the applied level, readback returns the raw code
package charger_regs_pkg;
  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_ID = 8'h03;
  localparam logic [7:0] ADDR_CHG = 8'h04;
  localparam logic [7:0] ADDR_SPC = 8'h05;
  localparam logic [7:0] ADDR_SAFE = 8'h06;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int ID_VEND_LSB = 5;
  localparam int ID_PN_LSB = 3;
  localparam int FCC_MSB = 6;
  localparam int FCC_LSB = 4;
  localparam int TERM_MSB = 2;
  localparam int TERM_LSB = 0;
  localparam int OVR_BIT = 5;
  localparam int SPF_BIT = 4;
  localparam int CD_BIT = 3;
  localparam int VREG_MSB = 2;
  localparam int VREG_LSB = 0;
  localparam int TMR_BIT = 7;
  localparam int SAFI_MSB = 6;
  localparam int SAFI_LSB = 4;
  localparam int SAFV_MSB = 3;
  localparam int SAFV_LSB = 0;
  // ****************************************************************
  // Identity and reset values
  // ****************************************************************
  // Arbitrary identity values
  localparam logic [2:0] VENDOR_CODE = 3'h5;
  localparam logic [2:0] REVISION = 3'h1;
  localparam logic [2:0] FCC_RST = 3'h0;
  localparam logic [2:0] TERM_RST = 3'h0;
  localparam logic OVR_RST = 1'h0;
  localparam logic [2:0] VREG_RST = 3'h0;
  localparam logic TMR_RST = 1'h0;
  localparam logic [2:0] SAFI_RST = 3'h0;
  localparam logic [3:0] SAFV_RST = 4'h0;
  localparam logic [3:0] SAFV_MAX = 4'hc;
  localparam logic [7:0] RD_ZERO = 8'h00;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint CLK_HZ = 20_000_000;
  localparam longint TIMER_SEC = 32;
  localparam longint TIMER_CYCLES = TIMER_SEC * CLK_HZ;
  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic cdPinLevel;
    logic specialActive;
    logic busRegulating;
  } status_in_t;
  typedef struct packed {
    logic reducedCurrent;
    logic [2:0] chargeCurrentCode;
    logic [2:0] terminationCurrentCode;
    logic [2:0] inputRegulationLevelCode;
    logic timerEnable;
    logic [2:0] safetyCurrentCode;
    logic [3:0] safetyVoltageLevel;
  } charge_cfg_t;
endpackage

// File: rtl/cfg_field.sv
// One host-writable configuration field
// Assumes write strobe and data are synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module cfg_field #(
  parameter int W = 3,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wrEn,
  input wire logic [W-1:0] wrData,
  output logic [W-1:0] q
);
  // ****************************************************************
  // Storage
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= RST;
    end else if (wrEn) begin
      q <= wrData;
    end
  end
endmodule
`default_nettype wire

// File: rtl/level_clamp.sv
// Saturating limiter for a level code
// Assumes a plain unsigned code
`timescale 1ns/10ps
`default_nettype none
module level_clamp #(
  parameter int W = 4,
  parameter logic [W-1:0] MAX = '1
) (
  input wire logic [W-1:0] code,
  output logic [W-1:0] level
);
  // ****************************************************************
  // Clamp
  // ****************************************************************
  always_comb begin
    level = (code > MAX) ? MAX : code;
  end
endmodule
`default_nettype wire

// File: rtl/charger_config_regs.sv
// Configuration and status registers 0x03 to 0x06 of the charger
// Assumes the I2C slave presents byte accesses as one-cycle strobes
`timescale 1ns/10ps
`default_nettype none
module charger_config_regs #(
  parameter longint TIMER_LEN = charger_regs_pkg::TIMER_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire charger_regs_pkg::reg_req_t req,
  output logic [7:0] rdData_r,
  output logic rdValid_r,
  output logic accessErr_r,
  input wire charger_regs_pkg::status_in_t status,
  input wire logic [1:0] partStrap,
  output charger_regs_pkg::charge_cfg_t cfg_r,
  output logic cfgUpdated_r,
  output logic timerExpired_r
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic wrChg;
  logic wrSpc;
  logic wrSafe;
  logic mapped;
  logic unmappedAccess;
  logic idWrite;
  logic [2:0] fastCode;
  logic [2:0] termCode;
  logic overrideBit;
  logic [2:0] vregCode;
  logic timerOff;
  logic [2:0] safiCode;
  logic [3:0] safvCode;
  logic [3:0] safvLevel;
  logic [1:0] pn_r;
  logic strapDone_r;
  logic cdLevel_r;
  logic specialFlag_r;
  logic [7:0] rdMux;
  logic [39:0] timerCnt_r;
  logic [39:0] timerCnt_nxt;
  logic timerDue;
  charger_regs_pkg::charge_cfg_t cfgNxt;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  always_comb begin
    wrChg = req.wr && (req.addr == charger_regs_pkg::ADDR_CHG);
    wrSpc = req.wr && (req.addr == charger_regs_pkg::ADDR_SPC);
    wrSafe = req.wr && (req.addr == charger_regs_pkg::ADDR_SAFE);
    case (req.addr)
      charger_regs_pkg::ADDR_ID: begin
        mapped = 1'b1;
      end
      charger_regs_pkg::ADDR_CHG: begin
        mapped = 1'b1;
      end
      charger_regs_pkg::ADDR_SPC: begin
        mapped = 1'b1;
      end
      charger_regs_pkg::ADDR_SAFE: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Writable fields
  // ****************************************************************
  cfg_field #(.W(3), .RST(charger_regs_pkg::FCC_RST)) uFcc (
    .clk(clk),
    .sys_rst(sys_rst),
    .wrEn(wrChg),
    .wrData(req.wrData[charger_regs_pkg::FCC_MSB:charger_regs_pkg::FCC_LSB]),
    .q(fastCode)
  );

  cfg_field #(.W(3), .RST(charger_regs_pkg::TERM_RST)) uTerm (
    .clk(clk),
    .sys_rst(sys_rst),
    .wrEn(wrChg),
    .wrData(req.wrData[charger_regs_pkg::TERM_MSB:charger_regs_pkg::TERM_LSB]),
    .q(termCode)
  );

  cfg_field #(.W(1), .RST(charger_regs_pkg::OVR_RST)) uOvr (
    .clk(clk),
    .sys_rst(sys_rst),
    .wrEn(wrSpc),
    .wrData(req.wrData[charger_regs_pkg::OVR_BIT]),
    .q(overrideBit)
  );

  cfg_field #(.W(3), .RST(charger_regs_pkg::VREG_RST)) uVreg (
    .clk(clk),
    .sys_rst(sys_rst),
    .wrEn(wrSpc),
    .wrData(req.wrData[charger_regs_pkg::VREG_MSB:charger_regs_pkg::VREG_LSB]),
    .q(vregCode)
  );

  cfg_field #(.W(1), .RST(charger_regs_pkg::TMR_RST)) uTmr (
    .clk(clk),
    .sys_rst(sys_rst),
    .wrEn(wrSafe),
    .wrData(req.wrData[charger_regs_pkg::TMR_BIT]),
    .q(timerOff)
  );

  cfg_field #(.W(3), .RST(charger_regs_pkg::SAFI_RST)) uSafi (
    .clk(clk),
    .sys_rst(sys_rst),
    .wrEn(wrSafe),
    .wrData(req.wrData[charger_regs_pkg::SAFI_MSB:charger_regs_pkg::SAFI_LSB]),
    .q(safiCode)
  );

  cfg_field #(.W(4), .RST(charger_regs_pkg::SAFV_RST)) uSafv (
    .clk(clk),
    .sys_rst(sys_rst),
    .wrEn(wrSafe),
    .wrData(req.wrData[charger_regs_pkg::SAFV_MSB:charger_regs_pkg::SAFV_LSB]),
    .q(safvCode)
  );

  level_clamp #(.W(4), .MAX(charger_regs_pkg::SAFV_MAX)) uSafvClamp (
    .code(safvCode),
    .level(safvLevel)
  );

  // ****************************************************************
  // Strap capture after reset release
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pn_r <= 2'h0;
      strapDone_r <= 1'b0;
    end else if (!strapDone_r) begin
      pn_r <= partStrap;
      strapDone_r <= 1'b1;
    end
  end

  // ****************************************************************
  // Status sampling
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cdLevel_r <= 1'b0;
    end else begin
      cdLevel_r <= status.cdPinLevel;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      specialFlag_r <= 1'b0;
    end else begin
      specialFlag_r <= status.specialActive && status.busRegulating;
      if (!status.specialActive) begin
        specialFlag_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Read data assembly
  // ****************************************************************
  always_comb begin
    rdMux = charger_regs_pkg::RD_ZERO;
    case (req.addr)
      charger_regs_pkg::ADDR_ID: begin
        rdMux[7:charger_regs_pkg::ID_VEND_LSB] = charger_regs_pkg::VENDOR_CODE;
        rdMux[4:charger_regs_pkg::ID_PN_LSB] = pn_r;
        rdMux[2:0] = charger_regs_pkg::REVISION;
      end
      charger_regs_pkg::ADDR_CHG: begin
        rdMux[charger_regs_pkg::FCC_MSB:charger_regs_pkg::FCC_LSB] = fastCode;
        rdMux[charger_regs_pkg::TERM_MSB:charger_regs_pkg::TERM_LSB] = termCode;
      end
      charger_regs_pkg::ADDR_SPC: begin
        rdMux[charger_regs_pkg::OVR_BIT] = overrideBit;
        rdMux[charger_regs_pkg::SPF_BIT] = specialFlag_r;
        rdMux[charger_regs_pkg::CD_BIT] = cdLevel_r;
        rdMux[charger_regs_pkg::VREG_MSB:charger_regs_pkg::VREG_LSB] = vregCode;
      end
      charger_regs_pkg::ADDR_SAFE: begin
        rdMux[charger_regs_pkg::TMR_BIT] = timerOff;
        rdMux[charger_regs_pkg::SAFI_MSB:charger_regs_pkg::SAFI_LSB] = safiCode;
        rdMux[charger_regs_pkg::SAFV_MSB:charger_regs_pkg::SAFV_LSB] = safvCode;
      end
      default: begin
        rdMux = charger_regs_pkg::RD_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdData_r <= charger_regs_pkg::RD_ZERO;
    end else if (req.rd) begin
      rdData_r <= rdMux;
    end
  end

  // ****************************************************************
  // Read strobe
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= req.rd;
    end
  end

  // ****************************************************************
  // Access checking
  // ****************************************************************
  always_comb begin
    unmappedAccess = (req.wr || req.rd) && !mapped;
    idWrite = req.wr && (req.addr == charger_regs_pkg::ADDR_ID);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      accessErr_r <= 1'b0;
    end else begin
      accessErr_r <= unmappedAccess || idWrite;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfgUpdated_r <= 1'b0;
    end else begin
      cfgUpdated_r <= wrChg || wrSpc || wrSafe;
    end
  end

  // ****************************************************************
  // Effective settings
  // ****************************************************************
  always_comb begin
    cfgNxt.reducedCurrent = overrideBit;
    cfgNxt.chargeCurrentCode = overrideBit ? 3'h0 : fastCode;
    cfgNxt.terminationCurrentCode = termCode;
    cfgNxt.inputRegulationLevelCode = vregCode;
    cfgNxt.timerEnable = !timerOff;
    cfgNxt.safetyCurrentCode = safiCode;
    cfgNxt.safetyVoltageLevel = safvLevel;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_r <= '0;
    end else begin
      cfg_r <= cfgNxt;
    end
  end

  // ****************************************************************
  // Host watchdog timer
  // ****************************************************************
  always_comb begin
    timerCnt_nxt = timerCnt_r;
    if (timerOff || req.wr || req.rd) begin
      timerCnt_nxt = 40'h0;
    end else if (timerCnt_r < 40'(TIMER_LEN)) begin
      timerCnt_nxt = timerCnt_r + 40'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timerCnt_r <= 40'h0;
    end else begin
      timerCnt_r <= timerCnt_nxt;
    end
  end

  // ****************************************************************
  // Expiry
  // ****************************************************************
  always_comb begin
    timerDue = !timerOff && (timerCnt_nxt >= 40'(TIMER_LEN));
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timerExpired_r <= 1'b0;
    end else begin
      timerExpired_r <= timerDue;
    end
  end
endmodule
`default_nettype wire

// File: testbench/charger_config_regs_assertions.sv
// Concurrent checks on the charger register bank ports
// Assumes binding into charger_config_regs
`timescale 1ns/10ps
`default_nettype none
module charger_config_regs_assertions #(
  parameter longint TIMER_LEN = charger_regs_pkg::TIMER_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire charger_regs_pkg::reg_req_t req,
  input wire logic [7:0] rdData_r,
  input wire logic rdValid_r,
  input wire logic accessErr_r,
  input wire charger_regs_pkg::status_in_t status,
  input wire logic [1:0] partStrap,
  input wire charger_regs_pkg::charge_cfg_t cfg_r,
  input wire logic cfgUpdated_r,
  input wire logic timerExpired_r
);
  // ****************************************
  // Checks
  // ****************************************
  logic wr4, wr5, wr6, rd4, rd5;
  logic [3:0] clampV;
  assign wr4 = req.wr && req.addr == 8'h04;
  assign wr5 = req.wr && req.addr == 8'h05;
  assign wr6 = req.wr && req.addr == 8'h06;
  assign rd4 = req.rd && req.addr == 8'h04;
  assign rd5 = req.rd && req.addr == 8'h05;
  assign clampV = (req.wrData[3:0] > 4'hc) ? 4'hc : req.wrData[3:0];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_fast_code_load: assert property (wr4 |-> ##2 (cfg_r.reducedCurrent ||
    cfg_r.chargeCurrentCode == $past(req.wrData[6:4], 2))) else $error("fast code not loaded");
  a_term_code_load: assert property (wr4 |-> ##2
    cfg_r.terminationCurrentCode == $past(req.wrData[2:0], 2)) else $error("term code bad");
  a_override_forces_low: assert property (cfg_r.reducedCurrent |->
    cfg_r.chargeCurrentCode == 3'h0) else $error("override ignored");
  a_flag_set: assert property (status.specialActive && status.busRegulating ##1 rd5
    |=> rdData_r[4]) else $error("special flag not set");
  a_flag_clear: assert property (!status.specialActive ##1 rd5 |=> !rdData_r[4])
    else $error("special flag not clear");
  a_vreg_code_load: assert property (wr5 |-> ##2
    cfg_r.inputRegulationLevelCode == $past(req.wrData[2:0], 2)) else $error("vreg code bad");
  a_timer_bit_load: assert property (wr6 |-> ##2
    cfg_r.timerEnable == !$past(req.wrData[7], 2)) else $error("timer enable bad");
  a_safe_cur_load: assert property (wr6 |-> ##2
    cfg_r.safetyCurrentCode == $past(req.wrData[6:4], 2)) else $error("safety current bad");
  a_safe_volt_clamp: assert property (wr6 |-> ##2
    cfg_r.safetyVoltageLevel == $past(clampV, 2)) else $error("safety voltage bad");
  a_reserved_zero: assert property (rd4 |=> rdData_r[7] == 1'b0 && rdData_r[3] == 1'b0)
    else $error("reserved bits not zero");
endmodule
bind charger_config_regs charger_config_regs_assertions #(.TIMER_LEN(TIMER_LEN)) chk (
  .clk(clk), .sys_rst(sys_rst), .req(req), .rdData_r(rdData_r), .rdValid_r(rdValid_r),
  .accessErr_r(accessErr_r), .status(status), .partStrap(partStrap), .cfg_r(cfg_r),
  .cfgUpdated_r(cfgUpdated_r), .timerExpired_r(timerExpired_r));
`default_nettype wire

// File: testbench/host_model.sv
// Host side of the register port, issuing single byte accesses
// Assumes requests are launched at the falling clock edge
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic clk,
  output var charger_regs_pkg::reg_req_t req
);
  initial req = '0;
  task automatic access(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req.addr = a;
    req.wrData = d;
    req.wr = w;
    req.rd = r;
    @(negedge clk);
    req.wr = 1'b0;
    req.rd = 1'b0;
    // Released bus shows the inverse of the last value
    req.addr = ~a;
    req.wrData = ~d;
  endtask
endmodule
`default_nettype wire

// File: testbench/charger_config_regs_03_06_tb.sv
// Self-checking bench for the charger register bank
// Assumes the host model and the checker files are compiled first
`timescale 1ns/10ps
`default_nettype none
module charger_config_regs_03_06_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  charger_regs_pkg::reg_req_t req;
  charger_regs_pkg::status_in_t status = '0;
  charger_regs_pkg::charge_cfg_t cfg;
  logic [7:0] rdData, v, a, d;
  logic [1:0] strap = 2'h0;
  logic rdValid, accessErr, cfgUpdated, timerExpired, e;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  int m4 = 0, m5 = 0, m6 = 0, flag = 0, cd = 0;
  always #25 clk = ~clk;
  host_model host (.clk(clk), .req(req));
  charger_config_regs #(.TIMER_LEN(20)) dut (.clk(clk), .sys_rst(rst), .req(req),
    .rdData_r(rdData), .rdValid_r(rdValid), .accessErr_r(accessErr), .status(status),
    .partStrap(strap), .cfg_r(cfg), .cfgUpdated_r(cfgUpdated), .timerExpired_r(timerExpired));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic rd(input logic [7:0] addr, output logic [7:0] val, output logic err);
    host.access(1'b0, 1'b1, addr, 8'h00);
    val = rdData;
    err = accessErr;
    check(rdValid, 1'b1);
  endtask
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    host.access(1'b1, 1'b0, addr, data);
    check(cfgUpdated, addr inside {8'h04, 8'h05, 8'h06});
    check(accessErr, addr == 8'h03);
    if (addr == 8'h04) m4 = data & 8'h77;
    if (addr == 8'h05) m5 = data & 8'h27;
    if (addr == 8'h06) m6 = data;
  endtask
  function automatic logic [7:0] expect_rd(input logic [7:0] addr);
    case (addr)
      8'h03: return {charger_regs_pkg::VENDOR_CODE, strap, charger_regs_pkg::REVISION};
      8'h04: return 8'(m4);
      8'h05: return 8'(m5 | (flag << 4) | (cd << 3));
      8'h06: return 8'(m6);
      default: return 8'h00;
    endcase
  endfunction
  task automatic cfg_chk();
    repeat (2) @(negedge clk);
    check(cfg.reducedCurrent, m5[5]);
    check(cfg.chargeCurrentCode, m5[5] ? 0 : m4[6:4]);
    check(cfg.terminationCurrentCode, m4[2:0]);
    check(cfg.inputRegulationLevelCode, m5[2:0]);
    check(cfg.timerEnable, !m6[7]);
    check(cfg.safetyCurrentCode, m6[6:4]);
    check(cfg.safetyVoltageLevel, (m6[3:0] > 12) ? 12 : m6[3:0]);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      end_of_test();
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    void'($urandom(59161));
    strap = 2'($urandom);
    repeat (3) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    cfg_chk();
    for (int i = 3; i < 8; i++) begin
      rd(8'(i), v, e);
      check(v, expect_rd(8'(i)));
      check(e, i == 7);
    end
    for (int i = 0; i < 40; i++) begin
      a = 8'h03 + 8'($urandom_range(3));
      d = 8'($urandom);
      status = charger_regs_pkg::status_in_t'(3'($urandom));
      flag = status.specialActive & status.busRegulating;
      cd = status.cdPinLevel;
      wr(a, d);
      cfg_chk();
      rd(a, v, e);
      check(v, expect_rd(a));
    end
    wr(8'h04, 8'h70);
    wr(8'h05, 8'h20);
    cfg_chk();
    wr(8'h05, 8'h00);
    cfg_chk();
    host.access(1'b1, 1'b0, 8'h03, 8'hff);
    check(accessErr, 1'b1);
    rd(8'h03, v, e);
    check(v, expect_rd(8'h03));
    wr(8'h06, 8'h0f);
    cfg_chk();
    repeat (30) @(negedge clk);
    check(timerExpired, 1'b1);
    wr(8'h06, 8'h80);
    repeat (30) @(negedge clk);
    check(timerExpired, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
